// *** src/spimsc_pkg.sv ***
/*
 * Shared types and constants for the serial peripheral port core.
 * Assumes a single 8-bit data path and a 3-bit master rate field.
 */
package spimsc_pkg;

   localparam int          BYTE_W    = 8;
   localparam int          CNT_W     = 3;
   localparam int          DIV_W     = 7;
   localparam int          EDGE_W    = 4;
   localparam logic [2:0]  RATE_NONE = 3'h7;
   localparam logic [2:0]  CNT_LAST  = 3'h7;
   localparam logic [2:0]  CNT_PREV  = 3'h6;
   localparam logic [2:0]  CNT_ZERO  = 3'h0;
   localparam logic [3:0]  EDGE_LAST = 4'hF;
   localparam logic [3:0]  EDGE_ZERO = 4'h0;
   localparam logic [6:0]  DIV_ONE   = 7'h01;
   localparam logic [6:0]  DIV_ZERO  = 7'h00;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;

   // Control register contents
   typedef struct packed {
      logic       en;
      logic       select_disable_bit;
      logic       master_select_bit;
      logic       clock_polarity_bit;
      logic       clock_phase_bit;
      logic [2:0] rate;
   } spimsc_ctrl_t;

   localparam spimsc_ctrl_t CTRL_RESET = '0;

   // Status register contents
   typedef struct packed {
      logic transfer_done_flag;
      logic write_collision_flag;
      logic select_error_flag;
      logic mode_fault_flag;
   } spimsc_stat_t;

   localparam spimsc_stat_t STAT_RESET = '0;

   typedef enum logic [0:0] {
      SPIMSC_IDLE,
      SPIMSC_SHIFT
   } spimsc_state_t;

endpackage : spimsc_pkg

// *** src/spimsc_core.sv ***
/*
 * Serial peripheral port core, master or slave, with software ports.
 * Assumes SCK_IN, SS_N_IN, MOSI_IN and MISO_IN come from pins; the bench
 * resolves the two-way pins from the enables.
 */
//
// Summary of operation
// - Master-select bit chooses master or slave role
// - Master data write starts transfer when idle
// - Shift in while out; copy byte on done
// - Done flag clears: status read, then data read
// - Slave shifts on master clock, byte completes flag
// - Late slave write: previous byte goes out
// - Polarity sets idle level; phase picks edges
// - Both ends share polarity and phase settings
// - Phase zero: first edge samples MSB
// - Phase one: first edge starts; select stays
// - Unselected slave leaves MISO undriven
// - Master, select enabled: low select sets fault
// - Fault: error request, disable, drop master
// - Select-disable ignores select for fault
// - Fault clears: status read, then control write
// - Master clock divides by 2 to 128
// - Bytes move most significant bit first
// - Write during transfer sets collision flag
// - Select rising mid-byte sets select error
`timescale 1ns/10ps

module spimsc_core (
   // Clocks and reset
   input  wire logic                   REF_CLK_IN,
   input  wire logic                   RESET_IN,
   input  wire logic                   SCK_IN,
   // Serial pins
   input  wire logic                   SS_N_IN,
   input  wire logic                   MOSI_IN,
   input  wire logic                   MISO_IN,
   output logic                        SCK_OUT,
   output logic                        SCK_OE_OUT,
   output logic                        MOSI_OUT,
   output logic                        MOSI_OE_OUT,
   output logic                        MISO_OUT,
   output logic                        MISO_OE_OUT,
   // Software side
   input  wire logic                   CTRL_WR_IN,
   input  wire spimsc_pkg::spimsc_ctrl_t CTRL_IN,
   input  wire logic                   STAT_RD_IN,
   input  wire logic                   DATA_RD_IN,
   input  wire logic                   DATA_WR_IN,
   input  wire logic [7:0]             DATA_IN,
   output spimsc_pkg::spimsc_ctrl_t    CTRL_OUT,
   output spimsc_pkg::spimsc_stat_t    STATUS_OUT,
   output logic [7:0]                  DATA_OUT,
   output logic                        ERR_REQ_OUT
);
   import spimsc_pkg::*;

   spimsc_ctrl_t  ctrl;
   spimsc_stat_t  stat;
   spimsc_state_t state;
   logic [7:0]    sh;
   logic [7:0]    tx_byte;
   logic [6:0]    div;
   logic [3:0]    edge_n;
   logic [2:0]    rcnt;
   logic          transfer_done_flag_arm;
   logic          mode_fault_flag_arm;
   logic          write_collision_flag_arm;
   logic          ss_m, ss_s, ss_d;
   logic          miso_m, miso_s;
   logic          btg_m, btg_s, btg_d;
   logic          slave_on;
   logic          miso_q;
   // Link domain
   logic [2:0]    cnt;
   logic [7:0]    rx_sh;
   logic [7:0]    rx_hold;
   logic          bit_tg;

   // Decoding
   wire        master    = ctrl.master_select_bit;
   wire        ss_used   = ~(ctrl.clock_phase_bit & ctrl.select_disable_bit);
   wire [6:0]  half_m1   = (DIV_ONE << ctrl.rate) - DIV_ONE;
   wire        tick      = (state == SPIMSC_SHIFT) && (div == half_m1);
   wire        samp_edge = (edge_n[0] == ctrl.clock_phase_bit);
   wire        last_edge = tick && (edge_n == EDGE_LAST);
   wire        can_start = ctrl.en && master && (state == SPIMSC_IDLE)
                           && (ctrl.rate != RATE_NONE);
   wire        m_start   = DATA_WR_IN && can_start;
   wire        fault     = master && !ctrl.select_disable_bit && !ss_s;
   wire        bit_evt   = slave_on && (btg_s != btg_d);
   wire        s_done    = bit_evt && (rcnt == CNT_LAST);
   wire        s_busy    = slave_on && (rcnt != CNT_ZERO);
   wire        ss_rise   = ss_s && !ss_d;
   wire        select_error_flag_set = slave_on && ss_used && ss_rise
                           && (rcnt != CNT_ZERO);
   wire        write_collision_flag_set  = DATA_WR_IN
                           && ((state == SPIMSC_SHIFT) || s_busy);
   wire        transfer_done_flag_set  = last_edge || s_done;
   wire [7:0]  m_rx      = {sh[6:0], miso_s};
   wire [7:0]  m_byte    = samp_edge ? m_rx : sh;
   wire        dis_wr    = CTRL_WR_IN && !CTRL_IN.en;
   wire        slave_ld  = DATA_WR_IN && !master && !s_busy;
   wire        next_slave_on = ctrl.en && !ctrl.master_select_bit;

   // Pin synchronisers
   always_ff @(posedge REF_CLK_IN) begin
      ss_m   <= SS_N_IN;
      ss_s   <= ss_m;
      ss_d   <= ss_s;
      miso_m <= MISO_IN;
      miso_s <= miso_m;
      btg_m  <= bit_tg;
      btg_s  <= btg_m;
      btg_d  <= btg_s;
   end

   // Control register
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         ctrl <= CTRL_RESET;
      end else if (fault) begin
         ctrl.en   <= 1'b0;
         ctrl.master_select_bit <= 1'b0;
      end else if (CTRL_WR_IN) begin
         ctrl <= CTRL_IN;
      end
   end

   // Master transfer sequencer
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN || fault || !ctrl.en || !master) begin
         state  <= SPIMSC_IDLE;
         div    <= DIV_ZERO;
         edge_n <= EDGE_ZERO;
      end else if (m_start) begin
         state  <= SPIMSC_SHIFT;
         div    <= DIV_ZERO;
         edge_n <= EDGE_ZERO;
      end else if (state == SPIMSC_SHIFT) begin
         div <= tick ? DIV_ZERO : div + DIV_ONE;
         if (tick) begin
            edge_n <= edge_n + 4'h1;
            if (edge_n == EDGE_LAST) begin
               state <= SPIMSC_IDLE;
            end
         end
      end
   end

   // Master shift register and pins
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         sh          <= BYTE_ZERO;
         SCK_OUT     <= 1'b0;
         MOSI_OUT    <= 1'b0;
         SCK_OE_OUT  <= 1'b0;
         MOSI_OE_OUT <= 1'b0;
      end else begin
         SCK_OE_OUT  <= ctrl.en && master;
         MOSI_OE_OUT <= ctrl.en && master;
         if (m_start) begin
            sh       <= DATA_IN;
            MOSI_OUT <= DATA_IN[7];
         end else if (tick) begin
            if (samp_edge) begin
               sh <= m_rx;
            end else begin
               MOSI_OUT <= sh[7];
            end
         end
         if (tick) begin
            SCK_OUT <= ~SCK_OUT;
         end else if (state == SPIMSC_IDLE) begin
            SCK_OUT <= ctrl.clock_polarity_bit;
         end
      end
   end

   // Slave bit tracking seen from the core clock
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN || !slave_on || (ss_used && ss_s)) begin
         rcnt <= CNT_ZERO;
      end else if (bit_evt) begin
         rcnt <= rcnt + 3'h1;
      end
   end

   // Slave transmit byte, receive data, role
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         tx_byte     <= BYTE_ZERO;
         DATA_OUT    <= BYTE_ZERO;
         slave_on    <= 1'b0;
         MISO_OE_OUT <= 1'b0;
         ERR_REQ_OUT <= 1'b0;
      end else begin
         slave_on    <= next_slave_on;
         MISO_OE_OUT <= slave_on && !(ss_used && ss_s);
         ERR_REQ_OUT <= stat.mode_fault_flag && !ctrl.select_disable_bit;
         if (slave_ld) begin
            tx_byte <= DATA_IN;
         end
         if (last_edge) begin
            DATA_OUT <= m_byte;
         end else if (s_done) begin
            DATA_OUT <= rx_hold;
         end
      end
   end

   // Status flags; a set always wins over a clear
   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         stat     <= STAT_RESET;
         transfer_done_flag_arm <= 1'b0;
         mode_fault_flag_arm <= 1'b0;
         write_collision_flag_arm <= 1'b0;
      end else begin
         if (transfer_done_flag_set) begin
            stat.transfer_done_flag <= 1'b1;
            transfer_done_flag_arm  <= 1'b0;
         end else if (DATA_RD_IN && transfer_done_flag_arm) begin
            stat.transfer_done_flag <= 1'b0;
            transfer_done_flag_arm  <= 1'b0;
         end else if (STAT_RD_IN && stat.transfer_done_flag) begin
            transfer_done_flag_arm  <= 1'b1;
         end
         if (fault) begin
            stat.mode_fault_flag <= 1'b1;
            mode_fault_flag_arm  <= 1'b0;
         end else if (CTRL_WR_IN && mode_fault_flag_arm) begin
            stat.mode_fault_flag <= 1'b0;
            mode_fault_flag_arm  <= 1'b0;
         end else if (STAT_RD_IN && stat.mode_fault_flag) begin
            mode_fault_flag_arm  <= 1'b1;
         end
         if (write_collision_flag_set) begin
            stat.write_collision_flag <= 1'b1;
            write_collision_flag_arm  <= 1'b0;
         end else if ((DATA_RD_IN || DATA_WR_IN) && write_collision_flag_arm) begin
            stat.write_collision_flag <= 1'b0;
            write_collision_flag_arm  <= 1'b0;
         end else if (STAT_RD_IN && stat.write_collision_flag) begin
            write_collision_flag_arm  <= 1'b1;
         end
         if (select_error_flag_set) begin
            stat.select_error_flag <= 1'b1;
         end else if (dis_wr) begin
            stat.select_error_flag <= 1'b0;
         end
      end
   end

   assign CTRL_OUT   = ctrl;
   assign STATUS_OUT = stat;

   // Link domain: sample edge is the rising edge of lclk
   wire lclk      = SCK_IN ^ (ctrl.clock_polarity_bit ^ ctrl.clock_phase_bit);
   wire link_rst  = ~slave_on;
   wire frame_rst = link_rst | (ss_used & SS_N_IN);
   wire [2:0] tx_idx = CNT_LAST - cnt;

   always_ff @(posedge lclk or posedge frame_rst) begin
      if (frame_rst) begin
         cnt <= CNT_ZERO;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end

   always_ff @(posedge lclk) begin
      rx_sh <= {rx_sh[6:0], MOSI_IN};
      if (cnt == CNT_LAST) begin
         rx_hold <= {rx_sh[6:0], MOSI_IN};
      end
   end

   always_ff @(posedge lclk or posedge link_rst) begin
      if (link_rst) begin
         bit_tg <= 1'b0;
      end else begin
         bit_tg <= ~bit_tg;
      end
   end

   // tx_byte is settled before the master clocks, so it is read here
   always_ff @(negedge lclk or posedge frame_rst) begin
      if (frame_rst) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= tx_byte[tx_idx];
      end
   end

   // Phase zero puts the MSB out before the first edge
   assign MISO_OUT = (!ctrl.clock_phase_bit && (cnt == CNT_ZERO)) ? tx_byte[7]
                                                         : miso_q;

   // Checks
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);

   chk_role_pins: assert property (
      MOSI_OE_OUT |-> $past(ctrl.master_select_bit) && $past(ctrl.en))
      else $error("MOSI driven while not master");
   chk_start_load: assert property (
      m_start |=> state == SPIMSC_SHIFT && MOSI_OUT == $past(DATA_IN[7]))
      else $error("Master write did not start transfer");
   chk_done_copy: assert property (
      last_edge |=> stat.transfer_done_flag && DATA_OUT == $past(m_byte))
      else $error("Done flag or received byte missing");
   chk_transfer_done_flag_hold: assert property (
      stat.transfer_done_flag && !transfer_done_flag_arm && !transfer_done_flag_set |=> stat.transfer_done_flag)
      else $error("Done flag cleared without status read");
   chk_slave_done: assert property (
      s_done |=> stat.transfer_done_flag && DATA_OUT == $past(rx_hold))
      else $error("Slave byte did not complete");
   chk_fault_set: assert property (
      fault |=> stat.mode_fault_flag && !ctrl.en && !ctrl.master_select_bit ##1 ERR_REQ_OUT
         || ctrl.select_disable_bit)
      else $error("Mode fault handling wrong");
   chk_select_disable_bit_ign: assert property (
      ctrl.select_disable_bit && !stat.mode_fault_flag && !CTRL_WR_IN |=> !stat.mode_fault_flag)
      else $error("Fault raised with select disabled");
   chk_mode_fault_flag_clear: assert property (
      stat.mode_fault_flag && !mode_fault_flag_arm && !fault |=> stat.mode_fault_flag)
      else $error("Fault flag cleared without status read");
   chk_sck_rate: assert property (
      state == SPIMSC_SHIFT && $changed(SCK_OUT) && ctrl.rate != 3'h0
         |=> $stable(SCK_OUT))
      else $error("SCK half period too short");
   chk_write_collision_flag_set: assert property (
      DATA_WR_IN && state == SPIMSC_SHIFT && !last_edge && !fault
         |=> stat.write_collision_flag && state == SPIMSC_SHIFT)
      else $error("Collision flag or transfer wrong");
   chk_select_error_flag_clr: assert property (
      dis_wr && !select_error_flag_set |=> !stat.select_error_flag)
      else $error("Select error not cleared by disable");
   chk_idle_sck: assert property (
      state == SPIMSC_IDLE && $past(state == SPIMSC_IDLE)
         && $stable(ctrl.clock_polarity_bit) |-> SCK_OUT == ctrl.clock_polarity_bit)
      else $error("Idle SCK not at polarity level");
   chk_miso_hiz: assert property (
      ss_used && ss_s && $past(ss_used && ss_s) |=> !MISO_OE_OUT)
      else $error("MISO driven while unselected");

   cov_master_byte: cover property (m_start ##[1:300] last_edge);
   cov_slave_byte:  cover property (s_done);
   cov_mode_fault:  cover property (fault);
   cov_collision:   cover property (write_collision_flag_set);

endmodule : spimsc_core

// *** tb/spimsc_peer.sv ***
/* Far-side model: an external slave or an external master on the pins.
   Assumes the bench resolves the pins, with pull-ups on released lines. */
`timescale 1ns/10ps
module spimsc_peer (
   // Pins seen
   input  wire logic sck_in,
   input  wire logic mosi_in,
   input  wire logic miso_in,
   // Pins driven
   output logic      sck_out,
   output logic      mosi_out,
   output logic      mosi_oe_out,
   output logic      miso_out,
   output logic      miso_oe_out,
   output logic      ss_n_out
);
   // Link clock 125 ns, well below peripheral/4
   localparam realtime HALF = 62.5;
   logic [7:0] s_tx;
   logic [7:0] s_rx;
   logic       s_pol;
   logic       s_pha;
   logic       s_new;
   int         s_edges;
   initial begin
      sck_out = 1'b0;
      mosi_out = 1'b1;
      mosi_oe_out = 1'b0;
      miso_oe_out = 1'b0;
      ss_n_out = 1'b1;
   end
   assign miso_out = s_tx[7];
   // Slave role: sample on one edge kind, shift on the other
   always @(sck_in) begin
      if (miso_oe_out) begin
         s_edges++;
         if ((sck_in != s_pol) != s_pha) begin
            s_rx = {s_rx[6:0], mosi_in};
         end else if (s_new) begin
            s_new = 1'b0;
         end else begin
            s_tx = {s_tx[6:0], ~s_tx[0]};
         end
      end
   end
   task automatic rest(input logic pol);
      sck_out = pol;
   endtask : rest
   task automatic set_ss(input logic v);
      ss_n_out = v;
   endtask : set_ss
   task automatic sload(input logic [7:0] tx, input logic pol, pha);
      s_tx = tx;
      s_pol = pol;
      s_pha = pha;
      s_new = pha;
      s_edges = 0;
      miso_oe_out = 1'b1;
   endtask : sload
   task automatic sstop;
      miso_oe_out = 1'b0;
   endtask : sstop
   // Master role: one frame of nbits, select low around it
   task automatic mxfer(input logic [7:0] tx, input int nbits,
                        input logic pol, pha, output logic [7:0] rx);
      logic [7:0] t;
      t = tx;
      rx = 8'h00;
      mosi_oe_out = 1'b1;
      ss_n_out = 1'b0;
      mosi_out = t[7];
      #(HALF);
      for (int i = 0; i < nbits; i++) begin
         sck_out = ~pol;
         if (pha) begin
            mosi_out = t[7];
            t = t << 1;
         end else begin
            rx = {rx[6:0], miso_in};
         end
         #(HALF);
         sck_out = pol;
         if (pha) begin
            rx = {rx[6:0], miso_in};
         end else begin
            t = t << 1;
            mosi_out = t[7];
         end
         #(HALF);
      end
      ss_n_out = 1'b1;
      mosi_oe_out = 1'b0;
   endtask : mxfer
endmodule : spimsc_peer

// *** tb/spimsc_core_tb.sv ***
/* Self-checking bench for the serial port core with a far-side model.
   Assumes the design's own assertions; pins resolved with pull-ups. */
`timescale 1ns/10ps
module spimsc_core_tb;
   import spimsc_pkg::*;
   localparam logic [3:0] CW = 4'h8;
   localparam logic [3:0] SR = 4'h4;
   localparam logic [3:0] DR = 4'h2;
   localparam logic [3:0] DW = 4'h1;
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   logic          ctrl_wr = 1'b0;
   logic          stat_rd = 1'b0;
   logic          data_rd = 1'b0;
   logic          data_wr = 1'b0;
   spimsc_ctrl_t  ctrl_in = '0;
   logic [7:0]    data_in = 8'h00;
   spimsc_ctrl_t  ctrl_out;
   spimsc_stat_t  status_out;
   logic [7:0]    data_out;
   logic          err_req, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic          p_sck, p_mosi, p_mosi_oe, p_miso, p_miso_oe, p_ss_n;
   wire           sck_w = sck_oe ? sck_o : p_sck;
   wire           mosi_w = mosi_oe ? mosi_o : (p_mosi_oe ? p_mosi : 1'b1);
   wire           miso_w = miso_oe ? miso_o : (p_miso_oe ? p_miso : 1'b1);
   int            fails = 0;
   int            n_compared = 0;
   always #5 ref_clk = ~ref_clk;
   spimsc_core dut (.REF_CLK_IN(ref_clk), .RESET_IN(rst), .SCK_IN(sck_w),
      .SS_N_IN(p_ss_n), .MOSI_IN(mosi_w), .MISO_IN(miso_w),
      .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe), .MOSI_OUT(mosi_o),
      .MOSI_OE_OUT(mosi_oe), .MISO_OUT(miso_o), .MISO_OE_OUT(miso_oe),
      .CTRL_WR_IN(ctrl_wr), .CTRL_IN(ctrl_in), .STAT_RD_IN(stat_rd),
      .DATA_RD_IN(data_rd), .DATA_WR_IN(data_wr), .DATA_IN(data_in),
      .CTRL_OUT(ctrl_out), .STATUS_OUT(status_out), .DATA_OUT(data_out),
      .ERR_REQ_OUT(err_req));
   spimsc_peer peer (.sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w),
      .sck_out(p_sck), .mosi_out(p_mosi), .mosi_oe_out(p_mosi_oe),
      .miso_out(p_miso), .miso_oe_out(p_miso_oe), .ss_n_out(p_ss_n));
   task automatic tick;
      @(posedge ref_clk) #1;
   endtask : tick
   task automatic check(input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic sw(input logic [3:0] s, input logic [7:0] d);
      {ctrl_wr, stat_rd, data_rd, data_wr} = s;
      ctrl_in = spimsc_ctrl_t'(d);
      data_in = d;
      tick;
      {ctrl_wr, stat_rd, data_rd, data_wr} = 4'h0;
      tick;
   endtask : sw
   // Role and format first with the port off, then enable
   task automatic cfg(input logic [7:0] c);
      sw(CW, c & 8'h7F);
      peer.rest(c[4]);
      sw(CW, c);
   endtask : cfg
   task automatic master_test(input logic [1:0] m, input logic [2:0] r);
      int n;
      int h;
      h = 1 << r;
      cfg({3'b101, m, r});
      peer.sload(8'hA5 ^ m, m[1], m[0]);
      sw(DW, 8'h5A + m);
      sw(DW, 8'hFF);
      check({4'h0, status_out}, 8'h04);
      n = 0;
      while (status_out.transfer_done_flag !== 1'b1 && n < 400) begin
         tick;
         n++;
      end
      check({7'h0, n >= 16 * h - 4 && n <= 16 * h + 2}, 8'h01);
      check(8'(peer.s_edges), 8'h10);
      check(data_out, 8'hA5 ^ m);
      check(peer.s_rx, 8'h5A + m);
      check({7'h0, sck_o}, {7'h0, m[1]});
      check({4'h0, status_out}, 8'h0C);
      sw(DR, 8'h00);
      check({4'h0, status_out}, 8'h0C);
      sw(SR, 8'h00);
      sw(DR, 8'h00);
      check({4'h0, status_out}, 8'h00);
      peer.sstop;
      $display("master format %0d done", m);
   endtask : master_test
   task automatic slave_test(input logic [1:0] m);
      logic [7:0] rx;
      cfg({3'b100, m, 3'h0});
      check({7'h0, miso_oe}, 8'h00);
      sw(DW, 8'hC3 ^ m);
      repeat (4) tick;
      peer.mxfer(8'h96 + m, 8, m[1], m[0], rx);
      repeat (8) tick;
      check(data_out, 8'h96 + m);
      check(rx, 8'hC3 ^ m);
      check({4'h0, status_out}, 8'h08);
      sw(SR, 8'h00);
      sw(DR, 8'h00);
      $display("slave format %0d done", m);
   endtask : slave_test
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   initial begin
      #300000;
      fails++;
      final_report;
   end
   initial begin
      logic [7:0] rx;
      repeat (20) tick;
      rst = 1'b0;
      tick;
      check(ctrl_out, 8'h00);
      check({4'h0, status_out}, 8'h00);
      for (int m = 0; m < 4; m++) master_test(2'(m), 3'h2);
      master_test(2'h0, 3'h4);
      for (int m = 0; m < 4; m++) slave_test(2'(m));
      cfg(8'h80);
      peer.mxfer(8'hF0, 4, 1'b0, 1'b0, rx);
      repeat (8) tick;
      check({4'h0, status_out}, 8'h02);
      sw(CW, 8'h00);
      check({4'h0, status_out}, 8'h00);
      $display("select error done");
      cfg(8'hA2);
      peer.set_ss(1'b0);
      repeat (6) tick;
      check({4'h0, status_out}, 8'h01);
      check(ctrl_out, 8'h02);
      check({7'h0, err_req}, 8'h01);
      peer.set_ss(1'b1);
      repeat (4) tick;
      sw(CW, 8'hA2);
      check({4'h0, status_out}, 8'h01);
      sw(SR, 8'h00);
      sw(CW, 8'hE2);
      check({4'h0, status_out}, 8'h00);
      check(ctrl_out, 8'hE2);
      check({7'h0, err_req}, 8'h00);
      peer.set_ss(1'b0);
      repeat (6) tick;
      check({4'h0, status_out}, 8'h00);
      check(ctrl_out, 8'hE2);
      peer.set_ss(1'b1);
      $display("mode fault done");
      final_report;
   end
endmodule : spimsc_core_tb
